//--- bench/hecm_host_model.sv
// Link-side host model that issues mailbox register accesses
`timescale 1ns/1ps
`default_nettype none

module hecm_host_model (
  input wire logic clk_lpc,
  output logic host_req,
  output logic host_wr,
  output logic [15:0] host_addr,
  output logic [7:0] host_wdata,
  input wire logic host_done,
  input wire logic [7:0] host_rdata
);
  int timeouts = 0;

  initial begin
    host_req = 1'b0;
    host_wr = 1'b0;
    host_addr = 16'h0000;
    host_wdata = 8'h00;
  end

  // ************************************************************
  // Link accesses
  // ************************************************************
  // Request stands across one rising edge, then wait for done
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] wd,
    output logic [7:0] rd);
    int n;
    n = 0;
    @(negedge clk_lpc);
    host_req = 1'b1;
    host_wr = wr;
    host_addr = a;
    host_wdata = wd;
    @(negedge clk_lpc);
    host_req = 1'b0;
    // Released lines do not keep the last value
    host_wr = ~wr;
    host_addr = ~a;
    host_wdata = ~wd;
    while (host_done !== 1'b1 && n < 40) begin
      @(negedge clk_lpc);
      n++;
    end
    if (n >= 40) begin
      timeouts++;
      $display("unexpected at %0t: no host done", $time);
    end
    rd = host_rdata;
  endtask

  // Byte mode transfers go lowest byte first
  task automatic put_bytes(input logic [15:0] a, input logic [31:0] w, input int nb);
    logic [7:0] d;
    for (int b = 0; b < nb; b++) begin
      access(1'b1, a + 16'(b), w[8*b +: 8], d);
    end
  endtask
endmodule

`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the four-instance mailbox register block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_sys, clk_lpc, arst_n, ce, ec_req, ec_wr, ec_ack;
  logic host_req, host_wr, host_busy, host_done;
  logic [3:0][15:0] host_bar;
  logic [31:0] ec_addr;
  logic [15:0] host_addr;
  logic [7:0] ec_wdata, ec_rdata, host_wdata, host_rdata, rd;
  logic [3:0] ibf_flag, obf_flag;
  int n_fail, checked;

  always #4 clk_sys = ~clk_sys;
  always #62.5 clk_lpc = ~clk_lpc;

  hecm_top DUT (.clk_sys, .arst_n, .ce, .host_bar, .ec_req, .ec_wr, .ec_addr, .ec_wdata,
    .ec_ack, .ec_rdata, .ibf_flag, .obf_flag, .clk_lpc, .host_req, .host_wr, .host_addr,
    .host_wdata, .host_busy, .host_done, .host_rdata);

  hecm_host_model HOST (.clk_lpc, .host_req, .host_wr, .host_addr, .host_wdata,
    .host_done, .host_rdata);

  // ************************************************************
  // Access and compare helpers
  // ************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s saw %h want %h", $time, m, seen, exp);
    end
  endtask

  task automatic fl(input logic [7:0] e);
    check({obf_flag, ibf_flag}, e, "flags");
  endtask

  function automatic logic [15:0] ha(input int i, input logic [2:0] o);
    return host_bar[i] + {13'h0000, o};
  endfunction

  function automatic logic [31:0] ea(input int i, input logic [9:0] o);
    return hecm_pkg::EC_BASE[i] + {22'h000000, o};
  endfunction

  task automatic hw(input int i, input logic [2:0] o, input logic [7:0] d);
    HOST.access(1'b1, ha(i, o), d, rd);
  endtask

  task automatic hr(input int i, input logic [2:0] o);
    HOST.access(1'b0, ha(i, o), 8'h00, rd);
  endtask

  // Controller access held until the ack pulse is seen
  task automatic ec(input logic wr, input logic [31:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    @(negedge clk_sys);
    ec_req = 1'b1;
    ec_wr = wr;
    ec_addr = a;
    ec_wdata = wd;
    do begin
      @(negedge clk_sys);
      n++;
    end while (ec_ack !== 1'b1 && n < 50);
    if (n >= 50) check(8'h00, 8'h01, "no ec ack");
    rd = ec_rdata;
    ec_req = 1'b0;
    ec_wr = ~wr;
    ec_addr = ~a;
    ec_wdata = ~wd;
    @(negedge clk_sys);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    fl(8'h00);
    for (int i = 0; i < 4; i++) begin
      hr(i, 3'h0);
      check(rd, 8'h00, "e2h0 reset");
      ec(1'b0, ea(i, 10'h108), 8'h00);
      check(rd, 8'h00, "h2e0 reset");
    end
    HOST.access(1'b0, 16'h0300, 8'h00, rd);
    check(rd, 8'hff, "unmapped host");
    check({6'h00, host_busy, host_done}, 8'h01, "link done");
    ec(1'b0, 32'h00000000, 8'h00);
    check(rd, 8'h00, "unmapped ec");
    $display("t_reset finished");
  endtask

  task automatic t_inst();
    for (int i = 0; i < 4; i++) begin
      hw(i, 3'h0, 8'h10 + 8'(i));
      fl({4'h0, 4'((1 << (i + 1)) - 1)});
    end
    for (int i = 0; i < 4; i++) begin
      ec(1'b0, ea(i, 10'h108), 8'h00);
      check(rd, 8'h10 + 8'(i), "h2e0 inst");
    end
    fl(8'h00);
    ec(1'b1, ea(3, 10'h000), 8'h77);
    fl(8'h08);
    ec(1'b0, ea(3, 10'h108), 8'h00);
    check(rd, 8'h77, "ec runtime write");
    $display("t_inst finished");
  endtask

  task automatic t_byte();
    hw(0, 3'h0, 8'ha5);
    fl(8'h01);
    ec(1'b0, ea(0, 10'h108), 8'h00);
    check(rd, 8'ha5, "h2e0");
    fl(8'h00);
    hw(0, 3'h1, 8'h3c);
    fl(8'h00);
    ec(1'b0, ea(0, 10'h109), 8'h00);
    check(rd, 8'h00, "h2e1 kept");
    ec(1'b1, ea(0, 10'h101), 8'hee);
    ec(1'b1, ea(0, 10'h100), 8'h5a);
    fl(8'h10);
    hr(0, 3'h1);
    check(rd, 8'h00, "e2h1 zero");
    fl(8'h10);
    hr(0, 3'h0);
    check(rd, 8'h5a, "e2h0");
    fl(8'h00);
    $display("t_byte finished");
  endtask

  task automatic t_cmd();
    logic [7:0] st;
    st = (8'h01 << hecm_pkg::ST_IBF) | (8'h01 << hecm_pkg::ST_CMD);
    hw(1, 3'h4, 8'h81);
    fl(8'h02);
    ec(1'b0, ea(1, 10'h104), 8'h00);
    check(rd, st, "ec status");
    hr(1, 3'h4);
    check(rd, st, "host status");
    hw(1, 3'h2, 8'h99);
    hr(1, 3'h4);
    check(rd, 8'h01 << hecm_pkg::ST_IBF, "cmd clear");
    ec(1'b0, ea(1, 10'h108), 8'h00);
    check(rd, 8'h81, "cmd byte");
    fl(8'h00);
    ec(1'b1, ea(1, 10'h104), 8'hf4);
    hr(1, 3'h4);
    check(rd, 8'hf4, "status view");
    $display("t_cmd finished");
  endtask

  task automatic t_four();
    ec(1'b1, ea(2, 10'h105), 8'h01);
    hr(2, 3'h5);
    check(rd, 8'h01, "mode view");
    HOST.put_bytes(ha(2, 3'h0), 32'h44332211, 3);
    fl(8'h00);
    hw(2, 3'h3, 8'h44);
    fl(8'h04);
    for (int b = 0; b < 4; b++) begin
      if (b == 3) fl(8'h04);
      ec(1'b0, ea(2, 10'h108 + 10'(b)), 8'h00);
      check(rd, 8'h11 * 8'(b + 1), "h2e word");
    end
    fl(8'h00);
    for (int b = 0; b < 4; b++) begin
      if (b == 3) fl(8'h00);
      ec(1'b1, ea(2, 10'h100 + 10'(b)), 8'ha0 + 8'(b));
    end
    fl(8'h40);
    for (int b = 0; b < 4; b++) begin
      if (b == 3) fl(8'h40);
      hr(2, 3'(b));
      check(rd, 8'ha0 + 8'(b), "e2h word");
    end
    fl(8'h00);
    $display("t_four finished");
  endtask

  // ************************************************************
  // Sequence, watchdog and verdict
  // ************************************************************
  task automatic final_report();
    n_fail += HOST.timeouts;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    final_report();
  end

  initial begin
    clk_sys = 1'b0;
    clk_lpc = 1'b0;
    arst_n = 1'b0;
    ce = 1'b1;
    ec_req = 1'b0;
    ec_wr = 1'b0;
    ec_addr = 32'h00000000;
    ec_wdata = 8'h00;
    n_fail = 0;
    checked = 0;
    for (int i = 0; i < 4; i++) begin
      host_bar[i] = 16'h0400 + 16'(8 * i);
    end
    repeat (2) @(negedge clk_lpc);
    @(negedge clk_sys);
    arst_n = 1'b1;
    t_reset();
    t_inst();
    t_byte();
    t_cmd();
    t_four();
    final_report();
  end
endmodule

`default_nettype wire

//--- logic/hecm_pkg.sv
// Constants shared by the host to controller mailbox channel
package hecm_pkg;

  // ************************************************************
  // Instances and address map
  // ************************************************************
  localparam int NINST = 4;
  localparam int NBYTE = 4;
  localparam logic [31:0] EC_BASE0 = 32'h000f0c00;
  localparam logic [31:0] EC_BASE1 = 32'h000f1000;
  localparam logic [31:0] EC_BASE2 = 32'h000f2800;
  localparam logic [31:0] EC_BASE3 = 32'h000f2c00;
  localparam logic [NINST-1:0][31:0] EC_BASE = {EC_BASE3, EC_BASE2, EC_BASE1, EC_BASE0};

  // Runtime offsets from the instance base
  localparam logic [2:0] OFS_DATA0 = 3'h0;
  localparam logic [2:0] OFS_DATA3 = 3'h3;
  localparam logic [2:0] OFS_CMD = 3'h4;
  localparam logic [2:0] OFS_BCTL = 3'h5;

  // Controller private offsets from the instance base
  localparam logic [9:0] EC_E2H0 = 10'h100;
  localparam logic [9:0] EC_STAT = 10'h104;
  localparam logic [9:0] EC_BCTL = 10'h105;
  localparam logic [9:0] EC_H2E0 = 10'h108;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_CMD = 3;
  localparam logic [7:0] ST_SW_MASK = 8'hf4;
  localparam int BCTL_FOUR = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] FLOAT_BYTE = 8'hff;

endpackage

//--- logic/hecm_top.sv
// Four-instance host to controller mailbox runtime register block
//
// Behaviour
// - Four independent mailbox instances with identical register sets.
// - Host address decodes as offset plus programmable per-instance I/O base.
// - Controller reaches instances at fixed internal bases, first register at base.
// - Controller may also access the runtime registers.
// - Four data bytes form one word, byte 0 lowest, reset to zero.
// - Host writes fill host-to-controller bytes; reads return controller-to-host bytes.
// - Any host data byte write clears the command flag.
// - Single-byte mode: host write of byte 0 sets input full.
// - Single-byte mode: host read of byte 0 clears output full.
// - Single-byte mode: host writes to bytes 1..3 are discarded.
// - Single-byte mode: host reads of bytes 1..3 return zero.
// - Single-byte mode: bytes 1..3 access leaves full flags unchanged.
// - Four-byte mode: host write of byte 3 sets input full.
// - Four-byte mode: host read of byte 3 clears output full.
// - Host command write lands in host-to-controller byte 0.
// - Host command write sets command and input full flags.
// - Controller can read the command flag.
// - Host read at offset 4 returns the controller status register.
`timescale 1ns/1ps
`default_nettype none

module hecm_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [3:0][15:0] host_bar,
  input wire logic ec_req,
  input wire logic ec_wr,
  input wire logic [31:0] ec_addr,
  input wire logic [7:0] ec_wdata,
  output logic ec_ack,
  output logic [7:0] ec_rdata,
  output logic [3:0] ibf_flag,
  output logic [3:0] obf_flag,
  input wire logic clk_lpc,
  input wire logic host_req,
  input wire logic host_wr,
  input wire logic [15:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic host_busy,
  output logic host_done,
  output logic [7:0] host_rdata
);

  // ************************************************************
  // State types
  // ************************************************************
  typedef struct packed {
    logic [3:0][3:0][7:0] h2e;
    logic [3:0][3:0][7:0] e2h;
    logic [3:0][7:0] stat;
    logic [3:0] four;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack_tgl;
    logic [7:0] hrdata;
    logic [7:0] ec_rdata;
    logic ec_ack;
  } hecm_sys_t;

  typedef struct packed {
    logic busy;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
  } hecm_lnk_t;

  hecm_sys_t s_r, s_nxt;
  hecm_lnk_t l_r, l_nxt;
  logic hev;
  logic hhit;
  logic [1:0] hix;
  logic [2:0] hofs;
  logic ec_hit;
  logic [1:0] ec_ix;
  logic [9:0] ec_ofs;

  // ************************************************************
  // Access functions
  // ************************************************************
  // Byte whose access moves the full flags in the given mode
  function automatic logic [1:0] flag_ix(input logic four);
    flag_ix = four ? 2'(hecm_pkg::OFS_DATA3) : 2'(hecm_pkg::OFS_DATA0);
  endfunction

  // Read view of the runtime registers
  function automatic logic [7:0] rt_rd(input hecm_sys_t s, input logic [1:0] i,
                                        input logic [2:0] ofs);
    rt_rd = hecm_pkg::ZERO_BYTE;
    if (ofs <= hecm_pkg::OFS_DATA3) begin
      if (s.four[i] || ofs == hecm_pkg::OFS_DATA0) begin
        rt_rd = s.e2h[i][ofs[1:0]];
      end
    end else if (ofs == hecm_pkg::OFS_CMD) begin
      rt_rd = s.stat[i];
    end else if (ofs == hecm_pkg::OFS_BCTL) begin
      rt_rd = {7'h00, s.four[i]};
    end
  endfunction

  // Side effects of a runtime register access
  function automatic hecm_sys_t rt_acc(input hecm_sys_t s, input logic [1:0] i,
                                        input logic [2:0] ofs, input logic wr,
                                        input logic [7:0] wd);
    rt_acc = s;
    if (wr && ofs <= hecm_pkg::OFS_DATA3) begin
      rt_acc.stat[i][hecm_pkg::ST_CMD] = 1'b0;
      if (s.four[i] || ofs == hecm_pkg::OFS_DATA0) begin
        rt_acc.h2e[i][ofs[1:0]] = wd;
      end
      if (ofs[1:0] == flag_ix(s.four[i])) begin
        rt_acc.stat[i][hecm_pkg::ST_IBF] = 1'b1;
      end
    end else if (wr && ofs == hecm_pkg::OFS_CMD) begin
      rt_acc.h2e[i][0] = wd;
      rt_acc.stat[i][hecm_pkg::ST_CMD] = 1'b1;
      rt_acc.stat[i][hecm_pkg::ST_IBF] = 1'b1;
    end else if (!wr && ofs <= hecm_pkg::OFS_DATA3) begin
      if (ofs[1:0] == flag_ix(s.four[i])) begin
        rt_acc.stat[i][hecm_pkg::ST_OBF] = 1'b0;
      end
    end
  endfunction

  // Read view of the controller private registers
  function automatic logic [7:0] ec_rd(input hecm_sys_t s, input logic [1:0] i,
                                        input logic [9:0] ofs);
    ec_rd = hecm_pkg::ZERO_BYTE;
    if (ofs[9:2] == hecm_pkg::EC_E2H0[9:2]) begin
      ec_rd = s.e2h[i][ofs[1:0]];
    end else if (ofs == hecm_pkg::EC_STAT) begin
      ec_rd = s.stat[i];
    end else if (ofs == hecm_pkg::EC_BCTL) begin
      ec_rd = {7'h00, s.four[i]};
    end else if (ofs[9:2] == hecm_pkg::EC_H2E0[9:2]) begin
      ec_rd = s.h2e[i][ofs[1:0]];
    end
  endfunction

  // Side effects of a controller private register access
  function automatic hecm_sys_t ec_acc(input hecm_sys_t s, input logic [1:0] i,
                                        input logic [9:0] ofs, input logic wr,
                                        input logic [7:0] wd);
    ec_acc = s;
    if (wr && ofs[9:2] == hecm_pkg::EC_E2H0[9:2]) begin
      ec_acc.e2h[i][ofs[1:0]] = wd;
      if (ofs[1:0] == flag_ix(s.four[i])) begin
        ec_acc.stat[i][hecm_pkg::ST_OBF] = 1'b1;
      end
    end else if (wr && ofs == hecm_pkg::EC_STAT) begin
      ec_acc.stat[i] = (s.stat[i] & ~hecm_pkg::ST_SW_MASK) | (wd & hecm_pkg::ST_SW_MASK);
    end else if (wr && ofs == hecm_pkg::EC_BCTL) begin
      ec_acc.four[i] = wd[hecm_pkg::BCTL_FOUR];
    end else if (!wr && ofs[9:2] == hecm_pkg::EC_H2E0[9:2]) begin
      if (ofs[1:0] == flag_ix(s.four[i])) begin
        ec_acc.stat[i][hecm_pkg::ST_IBF] = 1'b0;
      end
    end
  endfunction

  // ************************************************************
  // Address decode
  // ************************************************************
  // Host address and data stay still while the request toggle is in flight
  always_comb begin
    hhit = 1'b0;
    hix = 2'd0;
    for (int i = hecm_pkg::NINST - 1; i >= 0; i--) begin
      if (l_r.addr[15:3] == host_bar[i][15:3]) begin
        hhit = 1'b1;
        hix = 2'(i);
      end
    end
    hofs = l_r.addr[2:0];
  end

  always_comb begin
    ec_hit = 1'b0;
    ec_ix = 2'd0;
    for (int i = hecm_pkg::NINST - 1; i >= 0; i--) begin
      if (ec_addr[31:10] == hecm_pkg::EC_BASE[i][31:10]) begin
        ec_hit = 1'b1;
        ec_ix = 2'(i);
      end
    end
    ec_ofs = ec_addr[9:0];
  end

  assign hev = s_r.req_s2 != s_r.req_seen;

  // ************************************************************
  // System domain
  // ************************************************************
  // Host events take priority; a controller access waits a cycle,
  // so a flag set and a flag clear never meet in one cycle
  always_comb begin
    s_nxt = s_r;
    s_nxt.ec_ack = 1'b0;
    s_nxt.req_s1 = l_r.req_tgl;
    s_nxt.req_s2 = s_r.req_s1;
    if (hev) begin
      s_nxt.req_seen = s_r.req_s2;
      s_nxt.ack_tgl = ~s_r.ack_tgl;
      if (!hhit) begin
        s_nxt.hrdata = hecm_pkg::FLOAT_BYTE;
      end else begin
        if (!l_r.wr) begin
          s_nxt.hrdata = rt_rd(s_r, hix, hofs);
        end
        s_nxt = rt_acc(s_nxt, hix, hofs, l_r.wr, l_r.wdata);
      end
    end else if (ec_req && !s_r.ec_ack) begin
      s_nxt.ec_ack = 1'b1;
      s_nxt.ec_rdata = hecm_pkg::ZERO_BYTE;
      if (ec_hit && ec_ofs[9:3] == 7'h00) begin
        if (!ec_wr) begin
          s_nxt.ec_rdata = rt_rd(s_r, ec_ix, ec_ofs[2:0]);
        end
        s_nxt = rt_acc(s_nxt, ec_ix, ec_ofs[2:0], ec_wr, ec_wdata);
      end else if (ec_hit) begin
        if (!ec_wr) begin
          s_nxt.ec_rdata = ec_rd(s_r, ec_ix, ec_ofs);
        end
        s_nxt = ec_acc(s_nxt, ec_ix, ec_ofs, ec_wr, ec_wdata);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Link domain
  // ************************************************************
  always_comb begin
    l_nxt = l_r;
    l_nxt.done = 1'b0;
    l_nxt.ack_s1 = s_r.ack_tgl;
    l_nxt.ack_s2 = l_r.ack_s1;
    if (l_r.busy && l_r.ack_s2 != l_r.ack_seen) begin
      l_nxt.ack_seen = l_r.ack_s2;
      l_nxt.busy = 1'b0;
      l_nxt.done = 1'b1;
      l_nxt.rdata = s_r.hrdata;
    end else if (!l_r.busy && host_req) begin
      l_nxt.busy = 1'b1;
      l_nxt.req_tgl = ~l_r.req_tgl;
      l_nxt.wr = host_wr;
      l_nxt.addr = host_addr;
      l_nxt.wdata = host_wdata;
    end
  end

  always_ff @(posedge clk_lpc or negedge arst_n) begin
    if (!arst_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign ec_ack = s_r.ec_ack;
  assign ec_rdata = s_r.ec_rdata;
  assign host_busy = l_r.busy;
  assign host_done = l_r.done;
  assign host_rdata = l_r.rdata;

  always_comb begin
    for (int i = 0; i < hecm_pkg::NINST; i++) begin
      ibf_flag[i] = s_r.stat[i][hecm_pkg::ST_IBF];
      obf_flag[i] = s_r.stat[i][hecm_pkg::ST_OBF];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_cmd_sets_flags: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && hev && hhit && l_r.wr && hofs == hecm_pkg::OFS_CMD) |=>
      (s_r.stat[$past(hix)][hecm_pkg::ST_CMD] && s_r.stat[$past(hix)][hecm_pkg::ST_IBF]
       && s_r.h2e[$past(hix)][0] == $past(l_r.wdata)))
    else $error("command write did not set flags");

  a_data_clears_cmd: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && hev && hhit && l_r.wr && hofs <= hecm_pkg::OFS_DATA3) |=>
      !s_r.stat[$past(hix)][hecm_pkg::ST_CMD])
    else $error("data write left command flag set");

  a_legacy_ibf_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && hev && hhit && l_r.wr && hofs == hecm_pkg::OFS_DATA0 && !s_r.four[hix]) |=>
      s_r.stat[$past(hix)][hecm_pkg::ST_IBF])
    else $error("byte 0 write did not set input full");

  a_four_ibf_set: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && hev && hhit && l_r.wr && hofs == hecm_pkg::OFS_DATA3 && s_r.four[hix]) |=>
      s_r.stat[$past(hix)][hecm_pkg::ST_IBF])
    else $error("byte 3 write did not set input full");

  a_obf_read_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && hev && hhit && !l_r.wr && hofs[2] == 1'b0
     && hofs[1:0] == flag_ix(s_r.four[hix])) |=>
      !s_r.stat[$past(hix)][hecm_pkg::ST_OBF])
    else $error("flagged read did not clear output full");

  a_legacy_hi_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && hev && hhit && !l_r.wr && !s_r.four[hix] && hofs != hecm_pkg::OFS_DATA0
     && hofs <= hecm_pkg::OFS_DATA3) |=> s_r.hrdata == hecm_pkg::ZERO_BYTE)
    else $error("upper byte read in byte mode not zero");

  a_legacy_hi_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && hev && hhit && !s_r.four[hix] && hofs != hecm_pkg::OFS_DATA0
     && hofs <= hecm_pkg::OFS_DATA3) |=>
      ($stable(s_r.h2e) && $stable(ibf_flag) && $stable(obf_flag)))
    else $error("upper byte access in byte mode changed state");

  a_byte0_read_data: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && hev && hhit && !l_r.wr && hofs == hecm_pkg::OFS_DATA0) |=>
      s_r.hrdata == $past(s_r.e2h[hix][0]))
    else $error("byte 0 read returned wrong data");

  a_ec_ibf_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ce && !hev && ec_req && !s_r.ec_ack && !ec_wr && ec_hit
     && ec_ofs == hecm_pkg::EC_H2E0 && !s_r.four[ec_ix]) |=>
      (ec_ack && !s_r.stat[$past(ec_ix)][hecm_pkg::ST_IBF]))
    else $error("controller read did not clear input full");

  a_host_done_once: assert property (@(posedge clk_lpc) disable iff (!arst_n)
    host_done |-> (!host_busy ##1 !host_done))
    else $error("host completion not a single pulse");

endmodule

`default_nettype wire
